// *** rtl/flash_pr_pkg.sv ***
// Purpose: constants for the flash power and resume control block
// Assumes: 100 MHz system clock, SPI mode 0 on the serial pins
// Notes: delays that have no printed figure are parameters with plain defaults
package flash_pr_pkg;
   localparam int CLK_PERIOD_NS = 10;
   localparam logic [7:0] CMD_RESUME = 8'h7A;
   localparam logic [7:0] CMD_SUSPEND = 8'h75;
   localparam logic [7:0] CMD_POWER_DOWN = 8'hB9;
   localparam logic [7:0] CMD_WAKE_ID = 8'hAB;
   localparam logic [7:0] CMD_PARAM_READ = 8'h5A;
   localparam logic [7:0] CMD_RESET_ENABLE = 8'h66;
   localparam logic [7:0] CMD_RESET = 8'h99;
   localparam logic [7:0] STATUS_RESET = 8'h00;
   localparam logic [7:0] ARRAY_ERASED = 8'hFF;
   localparam int WIP_BIT = 0;
   localparam int SUS_BIT = 7;
   localparam int RESUME_WIP_NS = 200;
   localparam int RESUME_WIP_CYC = (RESUME_WIP_NS / CLK_PERIOD_NS) > 0 ?
      RESUME_WIP_NS / CLK_PERIOD_NS : 1;
   localparam int ID_DUMMY_BYTES = 3;
   localparam int CNT_W = 24;
endpackage : flash_pr_pkg

// *** rtl/pin_sync.sv ***
// Purpose: two-stage synchroniser for one pin level
// Assumes: input is asynchronous to clk
// Notes: first stage feeds only the second
`timescale 1ns/1ps
module pin_sync (
   input wire logic clk,      // System clock
   input wire logic resetn,   // Async reset, active low
   input wire logic init_val, // Unused; reset level is always low
   input wire logic pin_in,   // Asynchronous level
   output logic pin_out       // Synchronised level
);
   logic meta_reg;
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         meta_reg <= 1'b0;
         pin_out <= 1'b0;
      end else begin
         meta_reg <= pin_in;
         pin_out <= meta_reg;
      end
   end
   // init_val unused: constant reset keeps async reset clean
endmodule : pin_sync

// *** rtl/delay_timer.sv ***
// Purpose: loadable down-counter with a done pulse
// Assumes: load value is at least one
// Notes: a new load restarts the count
`timescale 1ns/1ps
module delay_timer
   import flash_pr_pkg::*;
(
   input wire logic clk,                // System clock
   input wire logic resetn,             // Async reset, active low
   input wire logic load,               // Start the count
   input wire logic [CNT_W-1:0] length, // Cycles to wait
   output logic busy,                   // Count running
   output logic done                    // One-cycle end pulse
);
   logic [CNT_W-1:0] count_reg;
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         count_reg <= '0;
         busy <= 1'b0;
         done <= 1'b0;
      end else begin
         done <= 1'b0;
         if (load) begin
            count_reg <= length;
            busy <= 1'b1;
         end else if (busy) begin
            if (count_reg <= CNT_W'(1)) begin
               busy <= 1'b0;
               done <= 1'b1;
            end
            count_reg <= count_reg - CNT_W'(1);
         end
      end
   end
endmodule : delay_timer

// *** rtl/flash_power_resume_control.sv ***
// Purpose: command control for resume, deep power-down and identify
// Assumes: host drives SPI mode 0; serial clock sampled by CLK
// Notes: program and erase cycle lengths are parameters
// Summary of operation
// - Resume only when suspended and idle
// - Resume clears suspend, sets busy quickly
// - Suspend sets flag, clears busy later
// - Power-down entered only by its command
// - Asleep: only wake and reset obeyed
// - Deselected and idle means standby
// - Power-down needs select rise at bit eight
// - Power-down takes effect after entry delay
// - Power-down refused while cycle runs
// - Power-up always lands in standby
// - Wake alone waits first wake delay
// - Identify: code, three dummies, MSB first
// - Identifier repeats until select rises
// - Wake with identify waits second delay
// - Wake ignored while write in progress
// - Parameter-table read command is supported
// - Delivered: array erased, status all zero
`timescale 1ns/1ps
module flash_power_resume_control
   import flash_pr_pkg::*;
#(
   parameter int POWER_DOWN_ENTRY_CYC = 300,
   parameter int FIRST_WAKE_CYC = 300,
   parameter int SECOND_WAKE_CYC = 180,
   parameter int SUSPEND_LATENCY_CYC = 2000,
   parameter int PROGRAM_CYC = 5000,
   parameter int RESET_CYC = 3000,
   parameter logic [7:0] DEVICE_ID = 8'h5C  // Arbitrary value
)(
   input wire logic CLK,          // System clock
   input wire logic RESETN,       // Power-on reset, active low
   input wire logic CS_N,         // Chip select, active low
   input wire logic SCLK,         // Serial clock from host
   input wire logic SI,           // Serial data in
   input wire logic START_CYCLE,  // Begin a program or erase
   output logic SO,               // Serial data out
   output logic SO_OE_N,          // Output enable, low drives
   output logic [7:0] STATUS,     // Status register image
   output logic DEEP_POWER_DOWN,  // Low-current mode active
   output logic STANDBY,          // Deselected and idle
   output logic PARAM_READ_START  // Table read begins, pulse
);
   typedef enum logic [2:0] {
      PW_ACTIVE = 3'b000,
      PW_ENTERING = 3'b001,
      PW_ASLEEP = 3'b010,
      PW_WAKING = 3'b011,
      PW_RESETTING = 3'b100
   } power_e;

   logic sel_s, sclk_s, si_s;
   logic sclk_d_reg;
   logic [7:0] shift_reg;
   logic [5:0] bit_cnt_reg;
   logic [7:0] opcode_reg;
   logic [7:0] id_shift_reg;
   logic cs_d_reg;
   logic wip_reg, sus_reg, reset_armed_reg;
   logic [CNT_W-1:0] work_left_reg;
   logic [CNT_W-1:0] timer_len;
   logic timer_load, timer_busy, timer_done;
   power_e power_reg;
   logic sus_pending_reg, resume_pending_reg;
   logic [CNT_W-1:0] wip_wait_reg;

   pin_sync u_sync_cs (.clk(CLK), .resetn(RESETN), .init_val(1'b0), .pin_in(~CS_N),
      .pin_out(sel_s));
   pin_sync u_sync_sclk (.clk(CLK), .resetn(RESETN), .init_val(1'b0), .pin_in(SCLK),
      .pin_out(sclk_s));
   pin_sync u_sync_si (.clk(CLK), .resetn(RESETN), .init_val(1'b0), .pin_in(SI),
      .pin_out(si_s));

   wire sclk_rise = sclk_s & ~sclk_d_reg;
   wire sclk_fall = ~sclk_s & sclk_d_reg;
   // Select synced high-true: sync reset means deselected, no false frame
   wire cs_n_s = ~sel_s;
   wire cs_rise = cs_n_s & ~cs_d_reg;
   wire selected = ~cs_n_s;
   // Byte count only: command byte alone, select rising after exactly eight bits
   wire frame_is_cmd_only = (bit_cnt_reg == 6'd8);
   wire sleeping = (power_reg == PW_ASLEEP) || (power_reg == PW_ENTERING);

   function automatic logic cmd_is(input logic [7:0] op, input logic [7:0] code);
      return op == code;
   endfunction : cmd_is

   // Bit and byte capture on host rising edges
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         sclk_d_reg <= 1'b0;
         cs_d_reg <= 1'b1;
         shift_reg <= 8'h00;
         bit_cnt_reg <= 6'd0;
         opcode_reg <= 8'h00;
      end else begin
         sclk_d_reg <= sclk_s;
         cs_d_reg <= cs_n_s;
         if (!selected) begin
            bit_cnt_reg <= 6'd0;
         end else if (sclk_rise) begin
            shift_reg <= {shift_reg[6:0], si_s};
            if (bit_cnt_reg != 6'd63) begin
               bit_cnt_reg <= bit_cnt_reg + 6'd1;
            end
            if (bit_cnt_reg == 6'd7) begin
               opcode_reg <= {shift_reg[6:0], si_s};
            end
         end
      end
   end

   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         id_shift_reg <= 8'h00;
         SO <= 1'b0;
         SO_OE_N <= 1'b1;
      end else begin
         if (!selected) begin
            SO_OE_N <= 1'b1;
         end else if (sclk_fall && cmd_is(opcode_reg, CMD_WAKE_ID) && !wip_reg
                      && power_reg == PW_ACTIVE
                      && bit_cnt_reg >= 6'(8 * (ID_DUMMY_BYTES + 1))) begin
            if (bit_cnt_reg[2:0] == 3'd0) begin
               SO <= DEVICE_ID[7];
               id_shift_reg <= {DEVICE_ID[6:0], DEVICE_ID[7]};
            end else begin
               SO <= id_shift_reg[7];
               id_shift_reg <= {id_shift_reg[6:0], id_shift_reg[7]};
            end
            SO_OE_N <= 1'b0;
         end
      end
   end

   // Timer length for each power transition
   always_comb begin
      timer_load = 1'b0;
      timer_len = CNT_W'(1);
      if (cs_rise && frame_is_cmd_only && !wip_reg) begin
         if (cmd_is(opcode_reg, CMD_POWER_DOWN) && power_reg == PW_ACTIVE) begin
            timer_load = 1'b1;
            timer_len = CNT_W'(POWER_DOWN_ENTRY_CYC);
         end else if (cmd_is(opcode_reg, CMD_WAKE_ID) && sleeping) begin
            timer_load = 1'b1;
            timer_len = CNT_W'(FIRST_WAKE_CYC);
         end else if (cmd_is(opcode_reg, CMD_RESET) && reset_armed_reg) begin
            timer_load = 1'b1;
            timer_len = CNT_W'(RESET_CYC);
         end
      end else if (cs_rise && !wip_reg && sleeping && cmd_is(opcode_reg, CMD_WAKE_ID)
                   && bit_cnt_reg > 6'd8) begin
         timer_load = 1'b1;
         timer_len = CNT_W'(SECOND_WAKE_CYC);
      end
   end

   delay_timer u_timer (.clk(CLK), .resetn(RESETN), .load(timer_load), .length(timer_len),
      .busy(timer_busy), .done(timer_done));

   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         power_reg <= PW_ACTIVE;
         reset_armed_reg <= 1'b0;
      end else begin
         if (cs_rise && frame_is_cmd_only) begin
            reset_armed_reg <= cmd_is(opcode_reg, CMD_RESET_ENABLE);
         end
         if (timer_load) begin
            if (cmd_is(opcode_reg, CMD_POWER_DOWN)) begin
               power_reg <= PW_ENTERING;
            end else if (cmd_is(opcode_reg, CMD_WAKE_ID)) begin
               power_reg <= PW_WAKING;
            end else begin
               power_reg <= PW_RESETTING;
            end
         end else if (timer_done) begin
            case (power_reg)
               PW_ENTERING: power_reg <= PW_ASLEEP;
               PW_WAKING: power_reg <= PW_ACTIVE;
               PW_RESETTING: power_reg <= PW_ACTIVE;
               default: power_reg <= power_reg;
            endcase
         end
      end
   end

   // Program/erase cycle, suspend and resume
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         wip_reg <= STATUS_RESET[WIP_BIT];
         sus_reg <= STATUS_RESET[SUS_BIT];
         work_left_reg <= '0;
         sus_pending_reg <= 1'b0;
         resume_pending_reg <= 1'b0;
         wip_wait_reg <= '0;
      end else begin
         if (power_reg == PW_RESETTING) begin
            wip_reg <= 1'b0;
            sus_reg <= 1'b0;
            sus_pending_reg <= 1'b0;
            resume_pending_reg <= 1'b0;
         end else if (cs_rise && frame_is_cmd_only && power_reg == PW_ACTIVE
                      && cmd_is(opcode_reg, CMD_SUSPEND) && wip_reg && !sus_reg) begin
            sus_reg <= 1'b1;
            sus_pending_reg <= 1'b1;
            wip_wait_reg <= CNT_W'(SUSPEND_LATENCY_CYC);
         end else if (cs_rise && frame_is_cmd_only && power_reg == PW_ACTIVE
                      && cmd_is(opcode_reg, CMD_RESUME) && sus_reg && !wip_reg
                      && !sus_pending_reg) begin
            sus_reg <= 1'b0;
            resume_pending_reg <= 1'b1;
            wip_wait_reg <= CNT_W'(RESUME_WIP_CYC);
         end else if (sus_pending_reg) begin
            if (wip_wait_reg <= CNT_W'(1)) begin
               wip_reg <= 1'b0;
               sus_pending_reg <= 1'b0;
            end
            wip_wait_reg <= wip_wait_reg - CNT_W'(1);
         end else if (resume_pending_reg) begin
            if (wip_wait_reg <= CNT_W'(1)) begin
               wip_reg <= 1'b1;
               resume_pending_reg <= 1'b0;
            end
            wip_wait_reg <= wip_wait_reg - CNT_W'(1);
         end else if (wip_reg && !sus_reg) begin
            if (work_left_reg <= CNT_W'(1)) begin
               wip_reg <= 1'b0;
            end
            work_left_reg <= work_left_reg - CNT_W'(1);
         end else if (START_CYCLE && !wip_reg && !sus_reg && power_reg == PW_ACTIVE) begin
            wip_reg <= 1'b1;
            work_left_reg <= CNT_W'(PROGRAM_CYC);
         end
      end
   end

   // Outputs from flip-flops
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         STATUS <= STATUS_RESET;
         DEEP_POWER_DOWN <= 1'b0;
         STANDBY <= 1'b1;
         PARAM_READ_START <= 1'b0;
      end else begin
         STATUS <= {sus_reg, 6'b000000, wip_reg};
         DEEP_POWER_DOWN <= (power_reg == PW_ASLEEP);
         STANDBY <= !selected && !wip_reg && power_reg == PW_ACTIVE && !timer_busy;
         PARAM_READ_START <= selected && sclk_rise && bit_cnt_reg == 6'd7
            && {shift_reg[6:0], si_s} == CMD_PARAM_READ && power_reg == PW_ACTIVE;
      end
   end
endmodule : flash_power_resume_control

// *** testbench/flash_pr_checker.sv ***
// Purpose: port-level checks for the flash power and resume block
// Assumes: sees only the top module ports; one clock domain
// Notes: long waits are counted in helper counters, not repetitions
`timescale 1ns/1ps
module flash_pr_checker
   import flash_pr_pkg::*;
#(
   parameter int POWER_DOWN_ENTRY_CYC = 300,
   parameter int SUSPEND_LATENCY_CYC = 2000
)(
   input wire logic CLK,              // System clock
   input wire logic RESETN,           // Reset, active low
   input wire logic CS_N,             // Chip select
   input wire logic SCLK,             // Serial clock
   input wire logic SI,               // Serial in
   input wire logic START_CYCLE,      // Cycle start
   input wire logic SO,               // Serial out
   input wire logic SO_OE_N,          // Output enable, low drives
   input wire logic [7:0] STATUS,     // Status image
   input wire logic DEEP_POWER_DOWN,  // Low-current mode
   input wire logic STANDBY,          // Standby level
   input wire logic PARAM_READ_START  // Table read pulse
);
   localparam int RW_MAX = RESUME_WIP_CYC + 4;
   logic [15:0] cs_hi_cnt;
   logic [15:0] sus_cnt;
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) cs_hi_cnt <= 16'h0000;
      else if (!CS_N) cs_hi_cnt <= 16'h0000;
      else if (cs_hi_cnt != 16'hFFFF) cs_hi_cnt <= cs_hi_cnt + 16'h0001;
   end
   // Overlap of suspend and busy must stay short
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) sus_cnt <= 16'h0000;
      else if (!(STATUS[SUS_BIT] && STATUS[WIP_BIT])) sus_cnt <= 16'h0000;
      else if (sus_cnt != 16'hFFFF) sus_cnt <= sus_cnt + 16'h0001;
   end
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RESETN);
   sequence cs_desel;
      CS_N [*4];
   endsequence
   sequence resume_seen;
      $fell(STATUS[SUS_BIT]) && !STATUS[WIP_BIT];
   endsequence
   a_status_reserved: assert property (STATUS[6:1] == 6'h00)
      else $error("reserved status bits set");
   a_resume_wip_fast: assert property (resume_seen |-> ##[1:RW_MAX] STATUS[WIP_BIT])
      else $error("busy flag late after resume");
   a_suspend_wip_clear: assert property (sus_cnt <= 16'(SUSPEND_LATENCY_CYC + 2))
      else $error("busy flag not cleared after suspend");
   a_dpd_entry_delay: assert property ($rose(DEEP_POWER_DOWN)
      |-> cs_hi_cnt >= 16'(POWER_DOWN_ENTRY_CYC))
      else $error("power-down entered too early");
   a_dpd_no_cycle: assert property ($rose(DEEP_POWER_DOWN) |-> !STATUS[WIP_BIT])
      else $error("power-down entered during a cycle");
   a_asleep_no_start: assert property (DEEP_POWER_DOWN && START_CYCLE
      |=> ##1 !STATUS[WIP_BIT])
      else $error("cycle started while asleep");
   a_standby_idle: assert property (STANDBY |-> !DEEP_POWER_DOWN && !STATUS[WIP_BIT])
      else $error("standby shown while busy or asleep");
   a_desel_no_drive: assert property (cs_desel |=> SO_OE_N)
      else $error("serial out driven while deselected");
   a_param_pulse: assert property (PARAM_READ_START |=> !PARAM_READ_START)
      else $error("table read start longer than one cycle");
endmodule : flash_pr_checker

bind flash_power_resume_control flash_pr_checker #(
   .POWER_DOWN_ENTRY_CYC(POWER_DOWN_ENTRY_CYC),
   .SUSPEND_LATENCY_CYC(SUSPEND_LATENCY_CYC)
) u_chk (.CLK(CLK), .RESETN(RESETN), .CS_N(CS_N), .SCLK(SCLK), .SI(SI),
   .START_CYCLE(START_CYCLE), .SO(SO), .SO_OE_N(SO_OE_N), .STATUS(STATUS),
   .DEEP_POWER_DOWN(DEEP_POWER_DOWN), .STANDBY(STANDBY),
   .PARAM_READ_START(PARAM_READ_START));

// *** testbench/spi_host_model.sv ***
// Purpose: host controller driving chip select, serial clock and data
// Assumes: mode 0, serial clock period 80 ns, clock low between frames
// Notes: data line shows the inverse of the last bit when idle
`timescale 1ns/1ps
module spi_host_model (
   input wire logic clk, // System clock
   input wire logic so,  // Serial data from device
   output logic cs_n,    // Chip select, active low
   output logic sclk,    // Serial clock
   output logic si       // Serial data to device
);
   initial begin
      cs_n = 1'b1;
      sclk = 1'b0;
      si = 1'b0;
   end
   task automatic frame(input logic [47:0] data, input int nbits, output logic [15:0] rx);
      rx = 16'h0000;
      @(posedge clk) cs_n <= 1'b0;
      repeat (2) @(posedge clk);
      for (int i = nbits - 1; i >= 0; i--) begin
         si <= data[i];
         repeat (4) @(posedge clk);
         sclk <= 1'b1;
         repeat (4) @(posedge clk);
         rx = {rx[14:0], so};
         sclk <= 1'b0;
      end
      repeat (4) @(posedge clk);
      cs_n <= 1'b1;
      si <= ~si;
      // Minimum deselect time so back-to-back frames are seen apart
      repeat (4) @(posedge clk);
   endtask : frame
endmodule : spi_host_model

// *** testbench/tb.sv ***
// Purpose: self-checking bench for the flash power and resume block
// Assumes: shortened delay parameters; host model drives the link
// Notes: status rows run in order, each depends on the one before
`timescale 1ns/1ps
module tb;
   import flash_pr_pkg::*;
   localparam logic [7:0] DEV_ID = 8'h3C; // Arbitrary value
   typedef struct {logic [47:0] data; int nbits; logic start; int waitc;
      logic [7:0] st; logic dpd;} row_s;
   logic CLK = 1'b0;
   logic RESETN = 1'b0;
   logic START_CYCLE = 1'b0;
   logic CS_N, SCLK, SI, SO, SO_OE_N, DEEP_POWER_DOWN, STANDBY, PARAM_READ_START;
   logic [7:0] STATUS;
   logic [15:0] rx;
   int miscompares = 0;
   int num_checks = 0;
   int prs_count = 0;
   row_s rows [14] = '{
      '{48'h7A, 8, 1'b0, 60, 8'h00, 1'b0}, '{48'h0, 0, 1'b1, 10, 8'h01, 1'b0},
      '{48'hB9, 8, 1'b0, 60, 8'h01, 1'b0}, '{48'hAB, 8, 1'b0, 60, 8'h01, 1'b0},
      '{48'h7A, 8, 1'b0, 60, 8'h01, 1'b0}, '{48'h75, 8, 1'b0, 60, 8'h80, 1'b0},
      '{48'h7A, 8, 1'b0, 60, 8'h01, 1'b0}, '{48'h0, 0, 1'b0, 900, 8'h00, 1'b0},
      '{48'h172, 9, 1'b0, 60, 8'h00, 1'b0}, '{48'hB9, 8, 1'b0, 60, 8'h00, 1'b1},
      '{48'h0, 0, 1'b1, 10, 8'h00, 1'b1}, '{48'hAB, 8, 1'b0, 60, 8'h00, 1'b0},
      '{48'hB9, 8, 1'b0, 60, 8'h00, 1'b1}, '{48'hAB000000, 32, 1'b0, 60, 8'h00, 1'b0}};
   always #5 CLK = ~CLK;
   always_ff @(posedge CLK) if (PARAM_READ_START === 1'b1) prs_count <= prs_count + 1;
   spi_host_model u_host (.clk(CLK), .so(SO), .cs_n(CS_N), .sclk(SCLK), .si(SI));
   flash_power_resume_control #(.POWER_DOWN_ENTRY_CYC(20), .FIRST_WAKE_CYC(20),
      .SECOND_WAKE_CYC(15), .SUSPEND_LATENCY_CYC(20), .PROGRAM_CYC(800),
      .DEVICE_ID(DEV_ID)) u_dut (.CLK(CLK), .RESETN(RESETN),
      .CS_N(CS_N), .SCLK(SCLK), .SI(SI), .START_CYCLE(START_CYCLE), .SO(SO),
      .SO_OE_N(SO_OE_N), .STATUS(STATUS), .DEEP_POWER_DOWN(DEEP_POWER_DOWN),
      .STANDBY(STANDBY), .PARAM_READ_START(PARAM_READ_START));
   task automatic cmp(input string name, input logic [15:0] exp, input logic [15:0] got);
      num_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
      end
   endtask : cmp
   task automatic give_verdict();
      if (miscompares == 0 && num_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : give_verdict
   initial begin
      repeat (20000) @(posedge CLK);
      miscompares++;
      give_verdict();
   end
   initial begin
      repeat (3) @(posedge CLK);
      #1;
      cmp("STATUS", 16'h0000, 16'(STATUS)); // Delivered status
      cmp("STANDBY", 16'h0001, 16'(STANDBY)); // Power-up state
      cmp("DEEP_POWER_DOWN", 16'h0000, 16'(DEEP_POWER_DOWN)); // Power-up state
      cmp("SO_OE_N", 16'h0001, 16'(SO_OE_N)); // Output off in reset
      repeat (3) @(posedge CLK);
      RESETN <= 1'b1;
      repeat (10) @(posedge CLK);
      for (int i = 0; i < 14; i++) begin
         if (rows[i].start) begin
            @(posedge CLK) START_CYCLE <= 1'b1;
            @(posedge CLK) START_CYCLE <= 1'b0;
         end
         if (rows[i].nbits > 0) u_host.frame(rows[i].data, rows[i].nbits, rx);
         repeat (rows[i].waitc) @(posedge CLK);
         #1;
         cmp("STATUS", 16'(rows[i].st), 16'(STATUS)); // Row status
         cmp("DEEP_POWER_DOWN", 16'(rows[i].dpd), 16'(DEEP_POWER_DOWN)); // Row mode
      end
      u_host.frame({8'hAB, 24'h000000, 16'h0000}, 48, rx);
      cmp("ID", {DEV_ID, DEV_ID}, rx); // Identifier twice
      repeat (8) @(posedge CLK);
      #1;
      cmp("SO_OE_N", 16'h0001, 16'(SO_OE_N)); // Released after read
      cmp("STANDBY", 16'h0001, 16'(STANDBY)); // Deselected idle
      // Power loss in deep power-down, then a mid-run reset release
      u_host.frame(48'hB9, 8, rx);
      repeat (60) @(posedge CLK);
      #1;
      cmp("DEEP_POWER_DOWN", 16'h0001, 16'(DEEP_POWER_DOWN)); // Asleep before loss
      @(posedge CLK) RESETN <= 1'b0;
      repeat (3) @(posedge CLK);
      RESETN <= 1'b1;
      repeat (2) @(posedge CLK);
      #1;
      cmp("DEEP_POWER_DOWN", 16'h0000, 16'(DEEP_POWER_DOWN)); // Power loss wakes
      cmp("STANDBY", 16'h0001, 16'(STANDBY)); // No false select after reset
      cmp("STATUS", 16'h0000, 16'(STATUS)); // Status clear after reset
      repeat (10) @(posedge CLK);
      // Software reset is obeyed while asleep
      u_host.frame(48'hB9, 8, rx);
      repeat (60) @(posedge CLK);
      #1;
      cmp("DEEP_POWER_DOWN", 16'h0001, 16'(DEEP_POWER_DOWN)); // Asleep again
      u_host.frame(48'h66, 8, rx);
      u_host.frame(48'h99, 8, rx);
      repeat (10) @(posedge CLK);
      #1;
      cmp("DEEP_POWER_DOWN", 16'h0000, 16'(DEEP_POWER_DOWN)); // Reset obeyed asleep
      cmp("STANDBY", 16'h0000, 16'(STANDBY)); // Reset still running
      repeat (3000) @(posedge CLK);
      #1;
      cmp("STANDBY", 16'h0001, 16'(STANDBY)); // Back to standby
      u_host.frame(48'h5A, 8, rx);
      repeat (10) @(posedge CLK);
      cmp("PARAM_READ_START", 16'h0001, 16'(prs_count)); // One table read
      give_verdict();
   end
endmodule : tb
